// file: pkg/kbd_mailbox_pkg.sv
package kbd_mailbox_pkg;

  // =====================================================
  // host i/o map
  localparam logic [15:0] DATA_ADDR = 16'h0060;
  localparam logic [15:0] CMD_ADDR = 16'h0064;
  localparam int SA2_BIT = 2;

  // =====================================================
  // status byte layout
  localparam int OBF_BIT = 0;
  localparam int IBF_BIT = 1;
  localparam int CMD_BIT = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] USER_MASK = 8'hF4;

  // =====================================================
  // port 2 bit positions
  localparam int A20_BIT = 1;
  localparam int MOUSE_DATA_PIN_OUT_BIT = 2;
  localparam int MCLK_OUT_BIT = 3;
  localparam int KEYBOARD_IRQ_GATE_BIT = 4;
  localparam int MOUSE_IRQ_GATE_BIT = 5;
  localparam int KEYBOARD_CLOCK_PIN_OUT_BIT = 6;
  localparam int KEYBOARD_DATA_PIN_OUT_BIT = 7;
  localparam logic [7:0] PORT2_RESET = 8'h00;

  // =====================================================
  // port 1 input bit positions
  localparam int KEYBOARD_DATA_PIN_IN_BIT = 0;
  localparam int MOUSE_DATA_PIN_IN_BIT = 1;

  // =====================================================
  // buffer depth and synchroniser length
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SOFT,
    PWR_HARD
  } power_e;

  // four serial interface lines, one bit each
  typedef struct packed {
    logic keyboard_clock_pin;
    logic keyboard_data_pin;
    logic mclk;
    logic mouse_data_pin;
  } ps2Lines_s;

  // one latched host access
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } hostAccess_s;

endpackage

// file: rtl/keyboard_host_mailbox.sv
// Functional notes
// [R1] 0x60 data/output byte, 0x64 command/status
// [R2] data write stores byte, clears command flag
// [R3] command write stores byte, sets command flag
// [R4] command flag follows SA2 on host writes
// [R5] status: OUTPUT_FULL_FLAG bit0, INPUT_FULL_FLAG bit1, C/D bit3
// [R6] status resets to 00H, host read-only
// [R7] CPU output write sets output full flag
// [R8] host data read clears output full flag
// [R9] flag mode: host data read clears keyboard_irq
// [R10] CPU input read clears INPUT_FULL_FLAG and interrupt
// [R11] flag mode: keyboard_irq is gate AND OUTPUT_FULL_FLAG
// [R12] no flag mode: keyboard_irq follows gate bit
// [R13] keyboard_irq low after reset
// [R14] flag mode: mouse_irq is gate AND NOT INPUT_FULL_FLAG
// [R15] no flag mode: mouse_irq follows gate bit
// [R16] a20 output driven from port bit
// [R17] four open-drain pins carry inverted bits
// [R18] pin levels returned on test and port inputs
// [R19] halt stops ALU clock, wakes on write/reset
// [R20] write wake calls ISR if INPUT_FULL_FLAG int enabled
// [R21] reset wake restarts at address zero
// [R22] stop halts oscillator, wakes on write/reset
// [R23] host strobes synchronised, one update each
module keyboard_host_mailbox (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // isa host port
  input wire logic [15:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic ioWrN,
  input wire logic ioRdN,
  output logic [7:0] hostRdData,
  output logic hostRdOe,
  // host interrupt lines and a20 gate
  output logic keyboardIrq,
  output logic mouseIrq,
  output logic addressLineGate,
  // embedded cpu data port
  input wire logic cpuInRead,
  output logic [7:0] cpuInByte,
  input wire logic cpuOutValid,
  output logic cpuOutReady,
  input wire logic [7:0] cpuOutData,
  // embedded cpu status and port access
  input wire logic cpuStatusWr,
  input wire logic [7:0] cpuStatusData,
  output logic [7:0] cpuStatus,
  input wire logic cpuPort2Wr,
  input wire logic [7:0] cpuPort2Data,
  output logic [7:0] cpuPort2,
  input wire logic cpuEnableFlags,
  output logic [1:0] cpuPort1In,
  output logic kclkIn,
  output logic mclkIn,
  output logic ibfInterrupt,
  // power control
  input wire logic cpuHalt,
  input wire logic cpuStop,
  input wire logic ibfIntEnable,
  output logic aluClockEnable,
  output logic oscEnable,
  output logic wakeCall,
  output logic wakeNext,
  output logic startAtZero,
  // open-drain serial pins
  input wire kbd_mailbox_pkg::ps2Lines_s pinIn,
  output kbd_mailbox_pkg::ps2Lines_s pinOut,
  output kbd_mailbox_pkg::ps2Lines_s pinOe
);

  logic wrSync;
  logic rdSync;
  logic wrSyncPrev_q;
  logic rdSyncPrev_q;
  logic wrStart;
  logic rdEnd;
  logic rdStart;
  kbd_mailbox_pkg::hostAccess_s acc_q;
  kbd_mailbox_pkg::ps2Lines_s pinSync;
  logic [7:0] inByte_q;
  logic [7:0] outByte_q;
  logic [7:0] status_q;
  logic [7:0] port2_q;
  logic flagMode_q;
  logic keyboard_irq_q;
  logic mouse_irq_q;
  logic rdIsData_q;
  logic hostWrite;
  logic hostDataRead;
  logic bufValid;
  logic bufReady;
  logic [7:0] bufData;
  logic outLoad;
  logic started_q;
  kbd_mailbox_pkg::power_e pwr_q;

  // =====================================================
  // address decode
  function automatic logic hitAddr(input logic [15:0] a);
    hitAddr = (a == kbd_mailbox_pkg::DATA_ADDR) ||
      (a == kbd_mailbox_pkg::CMD_ADDR);
  endfunction

  // =====================================================
  // strobe and pin synchronisers
  mailbox_sync wrSyncInst (
    .clk(clk),
    .srst(srst),
    .asyncIn(~ioWrN),
    .resetLevel(1'b0),
    .syncOut(wrSync)
  );

  mailbox_sync rdSyncInst (
    .clk(clk),
    .srst(srst),
    .asyncIn(~ioRdN),
    .resetLevel(1'b0),
    .syncOut(rdSync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      mailbox_sync pinSyncInst (
        .clk(clk),
        .srst(srst),
        .asyncIn(pinIn[gi]),
        .resetLevel(1'b1),
        .syncOut(pinSync[gi])
      );
    end
  endgenerate

  // =====================================================
  // one event per host strobe
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wrSyncPrev_q <= 1'b0;
      rdSyncPrev_q <= 1'b0;
    end
    else
    begin
      wrSyncPrev_q <= wrSync;
      rdSyncPrev_q <= rdSync;
    end
  end

  assign wrStart = wrSync && !wrSyncPrev_q; // [R23]
  assign rdStart = rdSync && !rdSyncPrev_q; // [R23]
  assign rdEnd = !rdSync && rdSyncPrev_q; // [R23]

  // =====================================================
  // latch address and data at strobe start
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      acc_q <= '0;
    end
    else if (wrStart || rdStart)
    begin
      acc_q <= '{addr: hostAddr, data: hostWrData};
    end
  end

  assign hostWrite = wrSync && !wrSyncPrev_q && hitAddr(hostAddr);

  // data read is recognised as the strobe ends, after the byte was taken
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdIsData_q <= 1'b0;
    end
    else if (rdStart)
    begin
      rdIsData_q <= (hostAddr == kbd_mailbox_pkg::DATA_ADDR); // [R1]
    end
  end

  assign hostDataRead = rdEnd && rdIsData_q; // [R8]

  // =====================================================
  // input byte
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      inByte_q <= 8'h00;
    end
    else if (hostWrite)
    begin
      inByte_q <= hostWrData; // [R2] [R3]
    end
  end

  assign cpuInByte = inByte_q;

  // =====================================================
  // output path through the two-entry buffer
  mailbox_pair_buffer outBuf (
    .clk(clk),
    .srst(srst),
    .inValid(cpuOutValid),
    .inReady(cpuOutReady),
    .inData(cpuOutData),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
  );

  // a new byte waits until the host has taken the previous one
  assign bufReady = !status_q[kbd_mailbox_pkg::OBF_BIT];
  assign outLoad = bufValid && bufReady;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outByte_q <= 8'h00;
    end
    else if (outLoad)
    begin
      outByte_q <= bufData; // [R7]
    end
  end

  // =====================================================
  // status register, hardware sets win over clears
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_q <= kbd_mailbox_pkg::STATUS_RESET; // [R6]
    end
    else
    begin
      if (cpuStatusWr)
      begin
        status_q <= (status_q & ~kbd_mailbox_pkg::USER_MASK) |
          (cpuStatusData & kbd_mailbox_pkg::USER_MASK); // [R5] [R6]
      end
      if (outLoad)
      begin
        status_q[kbd_mailbox_pkg::OBF_BIT] <= 1'b1; // [R7]
      end
      else if (hostDataRead)
      begin
        status_q[kbd_mailbox_pkg::OBF_BIT] <= 1'b0; // [R8]
      end
      if (hostWrite)
      begin
        status_q[kbd_mailbox_pkg::IBF_BIT] <= 1'b1; // [R2] [R3]
        status_q[kbd_mailbox_pkg::CMD_BIT] <=
          hostAddr[kbd_mailbox_pkg::SA2_BIT]; // [R4]
      end
      else if (cpuInRead)
      begin
        status_q[kbd_mailbox_pkg::IBF_BIT] <= 1'b0; // [R10]
      end
    end
  end

  assign cpuStatus = status_q;
  assign ibfInterrupt = status_q[kbd_mailbox_pkg::IBF_BIT]; // [R10]

  // =====================================================
  // host read data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hostRdData <= 8'h00;
    end
    else if (hostAddr[kbd_mailbox_pkg::SA2_BIT])
    begin
      hostRdData <= status_q; // [R1] [R5]
    end
    else
    begin
      hostRdData <= outByte_q; // [R1]
    end
  end

  assign hostRdOe = !ioRdN && hitAddr(hostAddr); // [R1]

  // =====================================================
  // port 2 and flag mode
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      port2_q <= kbd_mailbox_pkg::PORT2_RESET;
    end
    else if (cpuPort2Wr)
    begin
      port2_q <= cpuPort2Data;
    end
  end

  assign cpuPort2 = port2_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flagMode_q <= 1'b0;
    end
    else if (cpuEnableFlags)
    begin
      flagMode_q <= 1'b1;
    end
  end

  // =====================================================
  // host interrupt lines and a20 gate
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      keyboard_irq_q <= 1'b0; // [R13]
    end
    else if (flagMode_q)
    begin
      keyboard_irq_q <= port2_q[kbd_mailbox_pkg::KEYBOARD_IRQ_GATE_BIT] &&
        status_q[kbd_mailbox_pkg::OBF_BIT] && !hostDataRead; // [R9] [R11]
    end
    else
    begin
      keyboard_irq_q <= port2_q[kbd_mailbox_pkg::KEYBOARD_IRQ_GATE_BIT]; // [R12]
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mouse_irq_q <= 1'b0;
    end
    else if (flagMode_q)
    begin
      mouse_irq_q <= port2_q[kbd_mailbox_pkg::MOUSE_IRQ_GATE_BIT] &&
        !status_q[kbd_mailbox_pkg::IBF_BIT]; // [R14]
    end
    else
    begin
      mouse_irq_q <= port2_q[kbd_mailbox_pkg::MOUSE_IRQ_GATE_BIT]; // [R15]
    end
  end

  assign keyboardIrq = keyboard_irq_q;
  assign mouseIrq = mouse_irq_q;
  assign addressLineGate = port2_q[kbd_mailbox_pkg::A20_BIT]; // [R16]

  // =====================================================
  // open-drain pins: drive low while the port bit is one
  assign pinOut = '0; // [R17]
  assign pinOe = '{
    keyboard_clock_pin: port2_q[kbd_mailbox_pkg::KEYBOARD_CLOCK_PIN_OUT_BIT],
    keyboard_data_pin: port2_q[kbd_mailbox_pkg::KEYBOARD_DATA_PIN_OUT_BIT],
    mclk: port2_q[kbd_mailbox_pkg::MCLK_OUT_BIT],
    mouse_data_pin: port2_q[kbd_mailbox_pkg::MOUSE_DATA_PIN_OUT_BIT]
  }; // [R17]

  assign kclkIn = pinSync.keyboard_clock_pin; // [R18]
  assign mclkIn = pinSync.mclk; // [R18]
  assign cpuPort1In = {pinSync.mouse_data_pin, pinSync.keyboard_data_pin}; // [R18]

  // =====================================================
  // power-down control
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pwr_q <= kbd_mailbox_pkg::PWR_RUN; // [R19] [R22]
    end
    else
    begin
      unique case (pwr_q)
        kbd_mailbox_pkg::PWR_RUN:
        begin
          if (cpuStop)
          begin
            pwr_q <= kbd_mailbox_pkg::PWR_HARD; // [R22]
          end
          else if (cpuHalt)
          begin
            pwr_q <= kbd_mailbox_pkg::PWR_SOFT; // [R19]
          end
        end
        kbd_mailbox_pkg::PWR_SOFT, kbd_mailbox_pkg::PWR_HARD:
        begin
          if (hostWrite)
          begin
            pwr_q <= kbd_mailbox_pkg::PWR_RUN; // [R19] [R22]
          end
        end
        default:
        begin
          pwr_q <= kbd_mailbox_pkg::PWR_RUN;
        end
      endcase
    end
  end

  assign aluClockEnable = (pwr_q == kbd_mailbox_pkg::PWR_RUN); // [R19]
  assign oscEnable = (pwr_q != kbd_mailbox_pkg::PWR_HARD); // [R22]

  // wake pulses, one cycle each
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wakeCall <= 1'b0;
      wakeNext <= 1'b0;
    end
    else
    begin
      wakeCall <= (pwr_q != kbd_mailbox_pkg::PWR_RUN) && hostWrite &&
        ibfIntEnable; // [R20]
      wakeNext <= (pwr_q != kbd_mailbox_pkg::PWR_RUN) && hostWrite &&
        !ibfIntEnable; // [R20]
    end
  end

  // restart request for the first cycle after reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      started_q <= 1'b0;
    end
    else
    begin
      started_q <= 1'b1;
    end
  end

  assign startAtZero = !started_q && !srst; // [R21]

endmodule

// file: rtl/mailbox_pair_buffer.sv
module mailbox_pair_buffer (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [7:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [7:0] outData
);

  logic [7:0] mem_q [kbd_mailbox_pkg::BUF_DEPTH];
  logic rdPtr_q;
  logic wrPtr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != 2'(kbd_mailbox_pkg::BUF_DEPTH));
  assign outValid = (count_q != 2'h0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_q[rdPtr_q];

  // =====================================================
  // storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // =====================================================
  // pointers and fill count
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop)
      begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 2'h1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// file: rtl/mailbox_sync.sv
module mailbox_sync (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous level in, filtered level out
  input wire logic asyncIn,
  input wire logic resetLevel,
  output logic syncOut
);

  logic [kbd_mailbox_pkg::SYNC_STAGES-1:0] stage_q;

  // =====================================================
  // three flops, stage 0 read only by stage 1
  always_ff @(posedge clk)
  begin
    stage_q <= {stage_q[1:0], asyncIn};
  end

  // =====================================================
  // accept a change once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      syncOut <= resetLevel;
    end
    else if (stage_q[1] == stage_q[2])
    begin
      syncOut <= stage_q[2];
    end
  end

endmodule

// file: testbench/isa_host_model.sv
module isa_host_model (
  // clock
  input wire logic clk,
  // isa bus
  output logic [15:0] hostAddr,
  output logic [7:0] hostWrData,
  output logic ioWrN = 1'b1,
  output logic ioRdN = 1'b1,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdOe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial hostAddr = 16'h0000;
  initial hostWrData = 8'h00;

  // strobes low 4 cycles, high at least 4
  task automatic hostWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    hostAddr <= a;
    hostWrData <= d;
    ioWrN <= 1'b0;
    repeat (4) @(posedge clk);
    ioWrN <= 1'b1;
    repeat (4) @(posedge clk);
    hostWrData <= ~d;
  endtask

  task automatic hostRead(input logic [15:0] a, output logic [7:0] d,
    output logic oe);
    @(posedge clk);
    hostAddr <= a;
    ioRdN <= 1'b0;
    repeat (4) @(posedge clk);
    d = hostRdData;
    oe = hostRdOe;
    ioRdN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: testbench/keyboard_host_mailbox_monitor.sv
module keyboard_host_mailbox_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // host side
  input wire logic [15:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic ioWrN,
  input wire logic ioRdN,
  input wire logic hostRdOe,
  input wire logic keyboardIrq,
  input wire logic mouseIrq,
  input wire logic addressLineGate,
  // cpu side
  input wire logic cpuInRead,
  input wire logic [7:0] cpuInByte,
  input wire logic cpuOutValid,
  input wire logic cpuOutReady,
  input wire logic [7:0] cpuStatus,
  input wire logic [7:0] cpuPort2,
  input wire logic cpuEnableFlags,
  input wire logic ibfInterrupt,
  // pins
  input wire kbd_mailbox_pkg::ps2Lines_s pinOut,
  input wire kbd_mailbox_pkg::ps2Lines_s pinOe
);
  logic flagMode_q;

  always_ff @(posedge clk)
    if (srst)
      flagMode_q <= 1'b0;
    else if (cpuEnableFlags)
      flagMode_q <= 1'b1;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ==================================================
  // host side
  sequence s_wrFall;
    $fell(ioWrN) && (hostAddr == 16'h0060 || hostAddr == 16'h0064);
  endsequence
  sequence s_wrDone;
    cpuStatus[1] && cpuStatus[3] == hostAddr[2] && cpuInByte == hostWrData;
  endsequence
  sequence s_wrQuiet;
    ioWrN && $past(ioWrN, 2) && $past(ioWrN, 4) && $past(ioWrN, 6);
  endsequence
  property p_hostWr;
    s_wrFall |-> ##[3:6] s_wrDone;
  endproperty
  a_hostWr: assert property (p_hostWr)
    else $error("host write not taken");
  property p_rdOe;
    hostRdOe == (!ioRdN && (hostAddr == 16'h0060 || hostAddr == 16'h0064));
  endproperty
  a_rdOe: assert property (p_rdOe)
    else $error("read enable wrong");
  property p_ibfClr;
    cpuInRead ##0 s_wrQuiet |=> !cpuStatus[1] && !ibfInterrupt;
  endproperty
  a_ibfClr: assert property (p_ibfClr)
    else $error("input flag not cleared");
  property p_obfSet;
    cpuOutValid && cpuOutReady |-> ##[1:3] cpuStatus[0];
  endproperty
  a_obfSet: assert property (p_obfSet)
    else $error("output flag not set");

  // ==================================================
  // interrupt and pin outputs
  property p_kirqDir;
    !flagMode_q && !cpuEnableFlags |=> keyboardIrq == $past(cpuPort2[4]);
  endproperty
  a_kirqDir: assert property (p_kirqDir)
    else $error("keyboard irq not gate bit");
  property p_kirqFlag;
    flagMode_q && !(cpuPort2[4] && cpuStatus[0]) |=> !keyboardIrq;
  endproperty
  a_kirqFlag: assert property (p_kirqFlag)
    else $error("keyboard irq not gated");
  property p_mirqDir;
    !flagMode_q && !cpuEnableFlags |=> mouseIrq == $past(cpuPort2[5]);
  endproperty
  a_mirqDir: assert property (p_mirqDir)
    else $error("mouse irq not gate bit");
  property p_mirqFlag;
    flagMode_q |=> mouseIrq == ($past(cpuPort2[5]) && !$past(cpuStatus[1]));
  endproperty
  a_mirqFlag: assert property (p_mirqFlag)
    else $error("mouse irq not gated");
  property p_pins;
    pinOut == 4'h0 && addressLineGate == cpuPort2[1]
      && pinOe == {cpuPort2[6], cpuPort2[7], cpuPort2[3], cpuPort2[2]};
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin drive wrong");
endmodule

bind keyboard_host_mailbox keyboard_host_mailbox_monitor mon (.clk, .srst,
  .hostAddr, .hostWrData, .ioWrN, .ioRdN, .hostRdOe, .keyboardIrq,
  .mouseIrq, .addressLineGate, .cpuInRead, .cpuInByte, .cpuOutValid,
  .cpuOutReady, .cpuStatus, .cpuPort2, .cpuEnableFlags, .ibfInterrupt,
  .pinOut, .pinOe);

// file: testbench/keyboard_host_mailbox_test.sv
module keyboard_host_mailbox_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] hostAddr;
  logic [7:0] hostWrData, hostRdData, cpuInByte, cpuStatus, cpuPort2;
  logic ioWrN, ioRdN, hostRdOe, keyboardIrq, mouseIrq, addressLineGate;
  logic cpuInRead = 0, cpuOutValid = 0, cpuStatusWr = 0, cpuPort2Wr = 0;
  logic [7:0] cpuOutData = 8'h00, cpuStatusData = 8'h00, cpuPort2Data = 8'h00;
  logic cpuEnableFlags = 0, cpuHalt = 0, cpuStop = 0, ibfIntEnable = 0;
  logic cpuOutReady, kclkIn, mclkIn, ibfInterrupt, aluClockEnable;
  logic oscEnable, wakeCall, wakeNext, startAtZero, sawCall, sawNext;
  logic [1:0] cpuPort1In;
  kbd_mailbox_pkg::ps2Lines_s pinIn, pinOut, pinOe;
  logic [7:0] d;
  logic oe;
  int fail_count = 0;
  int n_tests = 0;

  always #10 clk = ~clk;
  // pull-ups on the open-drain lines
  assign pinIn = ~pinOe;
  always @(posedge clk)
  begin
    if (wakeCall)
      sawCall <= 1'b1;
    if (wakeNext)
      sawNext <= 1'b1;
  end

  keyboard_host_mailbox uut (.clk, .srst, .hostAddr, .hostWrData, .ioWrN,
    .ioRdN, .hostRdData, .hostRdOe, .keyboardIrq, .mouseIrq,
    .addressLineGate, .cpuInRead, .cpuInByte, .cpuOutValid, .cpuOutReady,
    .cpuOutData, .cpuStatusWr, .cpuStatusData, .cpuStatus, .cpuPort2Wr,
    .cpuPort2Data, .cpuPort2, .cpuEnableFlags, .cpuPort1In, .kclkIn,
    .mclkIn, .ibfInterrupt, .cpuHalt, .cpuStop, .ibfIntEnable,
    .aluClockEnable, .oscEnable, .wakeCall, .wakeNext, .startAtZero,
    .pinIn, .pinOut, .pinOe);
  isa_host_model host (.clk, .hostAddr, .hostWrData, .ioWrN, .ioRdN,
    .hostRdData, .hostRdOe);

  // ==================================================
  // helpers
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic port2(input logic [7:0] v);
    @(posedge clk);
    cpuPort2Wr <= 1'b1;
    cpuPort2Data <= v;
    @(posedge clk);
    cpuPort2Wr <= 1'b0;
    tick(6);
  endtask
  task automatic inRead;
    @(posedge clk);
    cpuInRead <= 1'b1;
    @(posedge clk);
    cpuInRead <= 1'b0;
    tick(2);
  endtask
  task automatic push(input logic [7:0] v);
    int i;
    @(posedge clk);
    cpuOutValid <= 1'b1;
    cpuOutData <= v;
    @(negedge clk);
    for (i = 0; i < 40 && cpuOutReady !== 1'b1; i++)
      @(negedge clk);
    if (i == 40)
    begin
      chk("push wait", 8'h01, 8'h00);
      finish_test();
    end
    @(posedge clk);
    cpuOutValid <= 1'b0;
  endtask

  // ==================================================
  // scenarios
  task automatic t_inbound;
    host.hostWrite(16'h0060, 8'h5A);
    chk("in byte", 8'h5A, cpuInByte);
    chk("status", 8'h02, cpuStatus);
    host.hostRead(16'h0064, d, oe);
    chk("host status", 8'h02, d);
    chk("read enable", 8'h01, oe);
    inRead();
    chk("status", 8'h00, cpuStatus);
    host.hostWrite(16'h0064, 8'hC3);
    chk("status", 8'h0A, cpuStatus);
    host.hostWrite(16'h0061, 8'h11);
    chk("in byte", 8'hC3, cpuInByte);
    inRead();
    @(posedge clk);
    cpuStatusWr <= 1'b1;
    cpuStatusData <= 8'hFF;
    @(posedge clk);
    cpuStatusWr <= 1'b0;
    tick(2);
    chk("user bits", 8'hFC, cpuStatus);
  endtask
  task automatic t_outbound;
    push(8'hA1);
    push(8'hA2);
    push(8'hA3);
    tick(3);
    chk("out ready", 8'h00, cpuOutReady);
    for (int k = 0; k < 3; k++)
    begin
      // the next byte reloads the flag on the edge the read task ends on
      tick(1);
      chk("obf", 8'h01, cpuStatus[0]);
      host.hostRead(16'h0060, d, oe);
      chk("out byte", 8'hA1 + k[7:0], d);
    end
    chk("obf", 8'h00, cpuStatus[0]);
    host.hostRead(16'h0062, d, oe);
    chk("read enable", 8'h00, oe);
  endtask
  task automatic t_ports;
    for (int k = 0; k < 4; k++)
    begin
      port2({2'b00, k[1:0], 4'h0});
      chk("keyboard_irq", {7'h00, k[0]}, keyboardIrq);
      chk("mouse_irq", {7'h00, k[1]}, mouseIrq);
    end
    port2(8'hCE);
    chk("pins", 8'h0F, pinOe);
    chk("a20", 8'h01, addressLineGate);
    chk("pin levels", 8'h00, {kclkIn, mclkIn, cpuPort1In});
    port2(8'h40);
    chk("pin levels", 8'h07, {kclkIn, mclkIn, cpuPort1In});
  endtask
  task automatic t_power;
    ibfIntEnable <= 1'b1;
    cpuHalt <= 1'b1;
    @(posedge clk);
    cpuHalt <= 1'b0;
    sawCall <= 1'b0;
    tick(2);
    chk("alu clock", 8'h00, aluClockEnable);
    host.hostWrite(16'h0060, 8'h01);
    chk("wake call", 8'h01, {aluClockEnable & sawCall});
    inRead();
    ibfIntEnable <= 1'b0;
    cpuStop <= 1'b1;
    @(posedge clk);
    cpuStop <= 1'b0;
    sawNext <= 1'b0;
    tick(2);
    chk("osc", 8'h00, oscEnable);
    host.hostWrite(16'h0064, 8'h02);
    chk("wake next", 8'h01, {oscEnable & sawNext});
    inRead();
  endtask
  task automatic t_flags;
    port2(8'h30);
    cpuEnableFlags <= 1'b1;
    @(posedge clk);
    cpuEnableFlags <= 1'b0;
    tick(3);
    chk("irqs", 8'h01, {keyboardIrq, mouseIrq});
    push(8'h77);
    tick(4);
    chk("keyboard_irq", 8'h01, keyboardIrq);
    host.hostWrite(16'h0060, 8'h33);
    chk("mouse_irq", 8'h00, mouseIrq);
    inRead();
    chk("mouse_irq", 8'h01, mouseIrq);
    host.hostRead(16'h0060, d, oe);
    chk("out byte", 8'h77, d);
    chk("keyboard_irq obf", 8'h00, {keyboardIrq, cpuStatus[0]});
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // restart request stands only in the cycle right after release
    @(negedge clk);
    chk("start", 8'h01, startAtZero);
    chk("status", 8'h00, cpuStatus);
    chk("keyboard_irq pins", 8'h00, {keyboardIrq, pinOe});
    t_inbound();
    t_outbound();
    t_ports();
    t_power();
    t_flags();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
